// ---- hw/esq_top.sv ----
// Event status register with its enable, summary bit, and the status, macro and
// identity query responses, sent out byte by byte.
// Assumes decoded commands, event pulses and macro writes from logic on ref_clk.
//
// Notes on behaviour
// - Status query returns register as decimal text, then clears every bit.
// - Reading the status register also clears the summary bit of the status byte.
// - Power-on bit set at reset; bit six always reads zero.
// - Parser syntax error sets bit five.
// - Instruction that cannot be executed sets bit four.
// - Any other device error sets bit three.
// - Read with no data or discarded data sets bit two.
// - Need to become active controller sets bit one.
// - No pending command after operation-complete sets bit zero.
// - Macro query returns the stored definition as a block response.
// - Undefined macro answers the empty block #10.
// - Identity query returns four comma fields; legacy name only in legacy mode.
// - Status bit reaches the summary only where its enable bit is one.
`timescale 1ns/1ps
module esq_top
    import esq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire esq_cmd_t cmd,
    input wire logic legacy_mode,
    input wire esq_evt_t evt,
    input wire esq_mac_wr_t mac_wr,
    input wire logic rsp_ready,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_last,
    output logic esb,
    output logic [7:0] sev_view,
    output logic [7:0] ese_view
);
    esq_state_t s;
    esq_state_t n;
    logic [3:0] dig_h;
    logic [3:0] dig_t;
    logic [3:0] dig_o;

    esq_dec u_dec (
        .value(s.snap),
        .hundreds(dig_h),
        .tens(dig_t),
        .ones(dig_o)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic take;
        logic [1:0] dpos;
        logic [4:0] bpos;
        logic [3:0] mlen;
        logic [7:0] byte_v;
        take = 1'b0;
        dpos = 2'd0;
        bpos = 5'd0;
        mlen = 4'd0;
        byte_v = 8'h00;
        n = s;
        take = cmd.valid && s.cmd_ready;

        // Status read clears before new events are merged in, so a same-cycle event survives
        if (take && cmd.op == ESQ_OP_SEV_Q) begin
            n.sev = 8'h00;
            n.snap = s.sev;
        end
        n.sev[SEV_CMD_BIT] = n.sev[SEV_CMD_BIT] | evt.cmd_err;
        n.sev[SEV_EXE_BIT] = n.sev[SEV_EXE_BIT] | evt.exe_err;
        n.sev[SEV_DEV_BIT] = n.sev[SEV_DEV_BIT] | evt.dev_err;
        n.sev[SEV_QRY_BIT] = n.sev[SEV_QRY_BIT] | evt.qry_err;
        n.sev[SEV_RQC_BIT] = n.sev[SEV_RQC_BIT] | evt.req_ctl;
        n.sev[SEV_OPC_BIT] = n.sev[SEV_OPC_BIT] | evt.opc_done;
        // Unknown legacy header counts as a grammar error
        if (take && cmd.op == ESQ_OP_LEGACY_IDENT_Q && !legacy_mode) begin
            n.sev[SEV_CMD_BIT] = 1'b1;
        end
        n.sev[SEV_ZERO_BIT] = 1'b0;

        if (take && cmd.op == ESQ_OP_ENABLE_SET) begin
            n.ese = cmd.arg;
        end
        n.esb = |(n.sev & n.ese);

        // Macro store, written in order from position zero
        if (mac_wr.del) begin
            n.mac_def[mac_wr.slot] = 1'b0;
            n.mac_len[mac_wr.slot] = 4'd0;
        end else if (mac_wr.wr && mac_wr.pos < 4'(MAC_LEN)) begin
            n.mac_def[mac_wr.slot] = 1'b1;
            n.mac_body[mac_wr.slot][mac_wr.pos] = mac_wr.data;
            n.mac_len[mac_wr.slot] = mac_wr.pos + 4'd1;
        end

        // Command start
        if (take) begin
            n.idx = 5'd0;
            case (cmd.op)
                ESQ_OP_SEV_Q: begin
                    n.src = ESQ_SRC_SEV;
                    n.st = ESQ_ST_SEND;
                    n.len = (s.sev >= 8'h64) ? 5'h3 : (s.sev >= 8'h0a) ? 5'h2 : 5'h1;
                end
                ESQ_OP_MACRO_Q: begin
                    n.src = ESQ_SRC_MACRO;
                    n.st = ESQ_ST_SEND;
                    n.slot = cmd.arg[1:0];
                    if (cmd.arg < 8'(MAC_SLOTS) && s.mac_def[cmd.arg[1:0]]) begin
                        n.len = 5'(MAC_HDR) + 5'(s.mac_len[cmd.arg[1:0]]);
                    end else begin
                        n.len = 5'(MAC_HDR);
                        n.slot = 2'd0;
                        n.mac_len[0] = s.mac_def[0] ? s.mac_len[0] : 4'd0;
                    end
                end
                ESQ_OP_IDENT_Q: begin
                    n.src = ESQ_SRC_IDENT;
                    n.st = ESQ_ST_SEND;
                    n.len = 5'(IDENT_LEN);
                end
                ESQ_OP_LEGACY_IDENT_Q: begin
                    if (legacy_mode) begin
                        n.src = ESQ_SRC_IDENT;
                        n.st = ESQ_ST_SEND;
                        n.len = 5'(IDENT_LEN);
                    end
                end
                default: begin
                end
            endcase
            // Empty reply for an undefined macro even if slot zero holds one
            if (cmd.op == ESQ_OP_MACRO_Q
                && !(cmd.arg < 8'(MAC_SLOTS) && s.mac_def[cmd.arg[1:0]])) begin
                n.src = ESQ_SRC_MACRO;
                n.len = 5'(MAC_HDR);
            end
        end

        // Current reply byte
        mlen = (s.len > 5'(MAC_HDR)) ? 4'(s.len - 5'(MAC_HDR)) : 4'd0;
        case (s.src)
            ESQ_SRC_SEV: begin
                dpos = 2'(s.idx) + 2'(5'd3 - s.len);
                case (dpos)
                    2'd0: byte_v = CH_ZERO + {4'h0, dig_h};
                    2'd1: byte_v = CH_ZERO + {4'h0, dig_t};
                    default: byte_v = CH_ZERO + {4'h0, dig_o};
                endcase
            end
            ESQ_SRC_MACRO: begin
                bpos = s.idx - 5'(MAC_HDR);
                if (s.idx == 5'd0) begin
                    byte_v = CH_HASH;
                end else if (s.idx == 5'd1) begin
                    byte_v = CH_ONE;
                end else if (s.idx == 5'd2) begin
                    byte_v = CH_ZERO + {4'h0, mlen};
                end else begin
                    byte_v = s.mac_body[s.slot][bpos[3:0]];
                end
            end
            default: begin
                byte_v = IDENT_STR[(IDENT_LEN - 1 - int'(s.idx)) * 8 +: 8];
            end
        endcase

        // Byte sequencing with hold under back-pressure
        case (s.st)
            ESQ_ST_SEND: begin
                if (!s.rsp_valid || rsp_ready) begin
                    n.rsp_valid = 1'b1;
                    n.rsp_data = byte_v;
                    n.rsp_last = (s.idx == s.len - 5'd1);
                    n.idx = s.idx + 5'd1;
                    if (s.idx == s.len - 5'd1) begin
                        n.st = ESQ_ST_IDLE;
                    end
                end
            end
            ESQ_ST_IDLE: begin
                if (s.rsp_valid && rsp_ready) begin
                    n.rsp_valid = 1'b0;
                    n.rsp_last = 1'b0;
                end
            end
            default: begin
                n.st = ESQ_ST_IDLE;
            end
        endcase
        n.cmd_ready = (n.st == ESQ_ST_IDLE) && !n.rsp_valid && !take;
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.sev <= SEV_RST;
            s.ese <= ESE_RST;
            s.st <= ESQ_ST_IDLE;
            s.src <= ESQ_SRC_SEV;
            s.cmd_ready <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign cmd_ready = s.cmd_ready;
    assign rsp_valid = s.rsp_valid;
    assign rsp_data = s.rsp_data;
    assign rsp_last = s.rsp_last;
    assign esb = s.esb;
    assign sev_view = s.sev;
    assign ese_view = s.ese;
endmodule // esq_top

// ---- hw/esq_pkg.sv ----
// Constants, types and state layout for the event status and identity query block.
// Assumes a single instrument clock and a command parser ahead of this block.
package esq_pkg;

    // ****************************************
    // Event status register layout
    // ****************************************
    localparam int SEV_W = 8;
    localparam int SEV_PON_BIT = 7;
    localparam int SEV_ZERO_BIT = 6;
    localparam int SEV_CMD_BIT = 5;
    localparam int SEV_EXE_BIT = 4;
    localparam int SEV_DEV_BIT = 3;
    localparam int SEV_QRY_BIT = 2;
    localparam int SEV_RQC_BIT = 1;
    localparam int SEV_OPC_BIT = 0;
    localparam logic [7:0] SEV_RST = 8'h80;
    localparam logic [7:0] ESE_RST = 8'h00;
    localparam int STB_ESB_BIT = 5;

    // ****************************************
    // Macro store and response text
    // ****************************************
    localparam int MAC_SLOTS = 4;
    localparam int MAC_LEN = 9;
    localparam int MAC_HDR = 3;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_HASH = 8'h23;
    localparam logic [7:0] CH_ONE = 8'h31;
    // Identity text; vendor and model fields are arbitrary neutral values
    localparam int IDENT_LEN = 27;
    localparam logic [IDENT_LEN*8-1:0] IDENT_STR = "NEUTRAL,MODEL-X,000000,1.00";

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        ESQ_OP_SEV_Q,
        ESQ_OP_MACRO_Q,
        ESQ_OP_IDENT_Q,
        ESQ_OP_LEGACY_IDENT_Q,
        ESQ_OP_ENABLE_SET
    } esq_op_t;

    typedef enum logic [0:0] {ESQ_ST_IDLE, ESQ_ST_SEND} esq_st_t;

    typedef enum logic [1:0] {ESQ_SRC_SEV, ESQ_SRC_MACRO, ESQ_SRC_IDENT} esq_src_t;

    typedef struct packed {
        logic cmd_err;
        logic exe_err;
        logic dev_err;
        logic qry_err;
        logic req_ctl;
        logic opc_done;
    } esq_evt_t;

    typedef struct packed {
        logic valid;
        esq_op_t op;
        logic [7:0] arg;
    } esq_cmd_t;

    typedef struct packed {
        logic wr;
        logic del;
        logic [1:0] slot;
        logic [3:0] pos;
        logic [7:0] data;
    } esq_mac_wr_t;

    typedef struct packed {
        logic [7:0] sev;
        logic [7:0] ese;
        logic esb;
        esq_st_t st;
        esq_src_t src;
        logic [4:0] idx;
        logic [4:0] len;
        logic [7:0] snap;
        logic [1:0] slot;
        logic cmd_ready;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic rsp_last;
        logic [MAC_SLOTS-1:0] mac_def;
        logic [MAC_SLOTS-1:0][3:0] mac_len;
        logic [MAC_SLOTS-1:0][MAC_LEN-1:0][7:0] mac_body;
    } esq_state_t;

endpackage

// ---- hw/esq_dec.sv ----
// Splits an 8-bit value into three decimal digits.
// Purely combinational; the caller registers whatever it takes from it.
`timescale 1ns/1ps
module esq_dec (
    input wire logic [7:0] value,
    output logic [3:0] hundreds,
    output logic [3:0] tens,
    output logic [3:0] ones
);
    logic [7:0] rem_v;

    always_comb begin
        rem_v = value;
        hundreds = 4'h0;
        tens = 4'h0;
        if (rem_v >= 8'hc8) begin
            hundreds = 4'h2;
            rem_v = rem_v - 8'hc8;
        end else if (rem_v >= 8'h64) begin
            hundreds = 4'h1;
            rem_v = rem_v - 8'h64;
        end
        tens = 4'(rem_v / 8'h0a);
        ones = 4'(rem_v % 8'h0a);
    end
endmodule // esq_dec

// ---- tb/esq_properties.sv ----
// Checker for the event status and query block.
// Bound into esq_top; sees only its ports, all on ref_clk.
`timescale 1ns/1ps
module esq_properties
    import esq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire esq_cmd_t cmd,
    input wire logic legacy_mode,
    input wire esq_evt_t evt,
    input wire esq_mac_wr_t mac_wr,
    input wire logic rsp_ready,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_last,
    input wire logic esb,
    input wire logic [7:0] sev_view,
    input wire logic [7:0] ese_view
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic rd_take;
    assign rd_take = cmd.valid && cmd_ready && cmd.op == ESQ_OP_SEV_Q;
    a_zero_bit: assert property (sev_view[6] == 1'b0)
        else $error("status bit six set");
    a_esb_sum: assert property (esb == |(sev_view & ese_view))
        else $error("summary bit wrong");
    a_evt_sets: assert property (1'b1 |=> (sev_view[5:0] & $past(evt)) == $past(evt))
        else $error("event bit not set");
    a_read_clears: assert property (rd_take && evt == '0 |=> sev_view == 8'h00)
        else $error("status read did not clear");
    a_bits_stay: assert property (!rd_take |=> (sev_view & $past(sev_view)) == $past(sev_view))
        else $error("status bit lost");
    a_reply_due: assert property (rd_take |=> !cmd_ready ##1 rsp_valid)
        else $error("status reply late");
    a_byte_holds: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
        else $error("reply byte dropped");
    a_last_ends: assert property (rsp_valid && rsp_ready && rsp_last |=> !rsp_valid)
        else $error("reply runs past last");
    c_read: cover property (rd_take);
    c_read_evt: cover property (rd_take && evt != '0);
    c_macro: cover property (cmd.valid && cmd_ready && cmd.op == ESQ_OP_MACRO_Q);
    c_legacy: cover property (cmd.valid && cmd_ready && legacy_mode);
endmodule // esq_properties

bind esq_top esq_properties esq_properties_i (
    .ref_clk(ref_clk),
    .rst(rst),
    .cmd(cmd),
    .legacy_mode(legacy_mode),
    .evt(evt),
    .mac_wr(mac_wr),
    .rsp_ready(rsp_ready),
    .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid),
    .rsp_data(rsp_data),
    .rsp_last(rsp_last),
    .esb(esb),
    .sev_view(sev_view),
    .ese_view(ese_view)
);

// ---- tb/esq_ctl_model.sv ----
// Bus controller model that reads reply bytes, promptly or stalling.
// Collects one reply into got; done pulses after its last byte.
`timescale 1ns/1ps
module esq_ctl_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_last,
    output logic rsp_ready,
    output logic [215:0] got,
    output logic done
);
    logic fresh;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rsp_ready <= 1'b0;
            got <= '0;
            done <= 1'b0;
            fresh <= 1'b1;
        end else begin
            // Stall every other cycle when slow
            rsp_ready <= slow ? ~rsp_ready : 1'b1;
            done <= rsp_valid && rsp_ready && rsp_last;
            if (rsp_valid && rsp_ready) begin
                got <= fresh ? {208'h0, rsp_data} : {got[207:0], rsp_data};
                fresh <= rsp_last;
            end
        end
    end
endmodule // esq_ctl_model

// ---- tb/tb.sv ----
// Testbench for the event status and query block.
// Drives commands, events and macro writes; the model reads replies.
`timescale 1ns/1ps
module tb;
    import esq_pkg::*;
    logic ref_clk, rst, slow, legacy_mode, rsp_ready, done;
    logic cmd_ready, rsp_valid, rsp_last, esb;
    logic [7:0] rsp_data, sev_view, ese_view;
    logic [215:0] got;
    esq_cmd_t cmd;
    esq_evt_t evt;
    esq_mac_wr_t mac_wr;
    int failures = 0;
    int check_count = 0;
    esq_top esq_top_i (
        .ref_clk(ref_clk),
        .rst(rst),
        .cmd(cmd),
        .legacy_mode(legacy_mode),
        .evt(evt),
        .mac_wr(mac_wr),
        .rsp_ready(rsp_ready),
        .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid),
        .rsp_data(rsp_data),
        .rsp_last(rsp_last),
        .esb(esb),
        .sev_view(sev_view),
        .ese_view(ese_view)
    );
    esq_ctl_model esq_ctl_model_i (
        .ref_clk(ref_clk),
        .rst(rst),
        .slow(slow),
        .rsp_valid(rsp_valid),
        .rsp_data(rsp_data),
        .rsp_last(rsp_last),
        .rsp_ready(rsp_ready),
        .got(got),
        .done(done)
    );
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [215:0] seen, input logic [215:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (failures == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic issue(input esq_op_t op, input logic [7:0] arg);
        do @(negedge ref_clk); while (cmd_ready !== 1'b1);
        @(posedge ref_clk) cmd <= '{1'b1, op, arg};
        @(posedge ref_clk) cmd.valid <= 1'b0;
    endtask
    task automatic query(input esq_op_t op, input logic [7:0] arg, output logic [215:0] r);
        issue(op, arg);
        do @(negedge ref_clk); while (done !== 1'b1);
        r = got;
    endtask
    task automatic mac(input logic del, input logic [3:0] pos, input logic [7:0] d);
        @(posedge ref_clk) mac_wr <= '{~del, del, 2'h1, pos, d};
        @(posedge ref_clk) mac_wr <= '0;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic [215:0] r;
        chk(sev_view, 8'h80);
        chk({esb, ese_view}, 9'h000);
        query(ESQ_OP_SEV_Q, 8'h00, r);
        chk(r, "128");
        chk(sev_view, 8'h00);
    endtask
    task automatic t_events();
        logic [7:0] acc;
        logic [215:0] r;
        acc = 8'h00;
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk) evt <= esq_evt_t'(6'h01 << i);
            @(posedge ref_clk) evt <= '0;
            acc[i] = 1'b1;
            @(negedge ref_clk);
            chk(sev_view, acc);
            chk(esb, 1'b0);
        end
        issue(ESQ_OP_ENABLE_SET, 8'h20);
        @(negedge ref_clk);
        chk(esb, 1'b1);
        chk(ese_view, 8'h20);
        query(ESQ_OP_SEV_Q, 8'h00, r);
        chk(r, "63");
        chk({esb, sev_view}, 9'h000);
    endtask
    task automatic t_macro();
        logic [215:0] r;
        mac(1'b0, 4'h0, 8'h41);
        mac(1'b0, 4'h1, 8'h42);
        query(ESQ_OP_MACRO_Q, 8'h01, r);
        chk(r, "#12AB");
        query(ESQ_OP_MACRO_Q, 8'h02, r);
        chk(r, "#10");
        mac(1'b1, 4'h0, 8'h00);
        query(ESQ_OP_MACRO_Q, 8'h01, r);
        chk(r, "#10");
    endtask
    task automatic t_ident();
        logic [215:0] r;
        query(ESQ_OP_IDENT_Q, 8'h00, r);
        chk(r, IDENT_STR);
        issue(ESQ_OP_LEGACY_IDENT_Q, 8'h00);
        repeat (2) @(negedge ref_clk);
        chk(sev_view[5], 1'b1);
        chk(esb, 1'b1);
        @(posedge ref_clk) legacy_mode <= 1'b1;
        query(ESQ_OP_LEGACY_IDENT_Q, 8'h00, r);
        chk(r, IDENT_STR);
    endtask
    // Event lands at the very edge that takes the status query
    task automatic t_same_cycle();
        logic [215:0] r;
        do @(negedge ref_clk); while (cmd_ready !== 1'b1);
        @(posedge ref_clk);
        cmd <= '{1'b1, ESQ_OP_SEV_Q, 8'h00};
        evt <= esq_evt_t'(6'h10);
        @(posedge ref_clk);
        cmd.valid <= 1'b0;
        evt <= '0;
        do @(negedge ref_clk); while (done !== 1'b1);
        r = got;
        chk(r, "32");
        chk(sev_view, 8'h10);
        chk(esb, 1'b0);
    endtask
    task automatic t_reset_again();
        logic [215:0] r;
        @(posedge ref_clk) rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk(sev_view, 8'h80);
        chk({esb, ese_view}, 9'h000);
        query(ESQ_OP_SEV_Q, 8'h00, r);
        chk(r, "128");
    endtask
    initial begin
        rst = 1'b1;
        slow = 1'b1;
        legacy_mode = 1'b0;
        cmd = '0;
        evt = '0;
        mac_wr = '0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        t_reset();
        @(posedge ref_clk) slow <= 1'b0;
        t_events();
        t_macro();
        t_ident();
        t_same_cycle();
        t_reset_again();
        stop_test();
    end
    // Cuts a hang short
    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        stop_test();
    end
endmodule // tb
